// File: hw/scwr_link_rx.sv
// Link-side receiver: serial clock domain shift register and byte counter.
// Assumes the serial clock runs only during frames; start/stop are
// seen by the data pin toggling while the serial clock is high.
`timescale 1ns/10ps
module scwr_link_rx
   import scwr_pkg::*;
(
   input wire logic serial_clock_pin_in,
   input wire logic serial_data_pin_in,
   input wire logic rst_n_in,
   output logic start_toggle_out,
   output logic byte_toggle_out,
   output scwr_byte_t byte_out
);
   // ==========================================================
   // Start and stop detection on data edges while clock is high
   logic start_q;
   logic stop_q;
   // Reset acts at once: no data edge need come while it is held
   always_ff @(negedge serial_data_pin_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         start_q <= 1'b0;
      end else if (serial_clock_pin_in) begin
         start_q <= ~start_q;
      end
   end
   always_ff @(posedge serial_data_pin_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         stop_q <= 1'b0;
      end else if (serial_clock_pin_in) begin
         stop_q <= ~stop_q;
      end
   end

   // ==========================================================
   // Bit shifting and byte sequencing
   logic seen_start_q, seen_start_d;
   logic seen_stop_q, seen_stop_d;
   logic [7:0] shift_q, shift_d;
   logic [2:0] bit_q, bit_d;
   logic [3:0] byte_q, byte_d;
   logic match_q, match_d;
   logic tog_q, tog_d;
   logic stog_q, stog_d;
   scwr_byte_t out_q, out_d;
   logic [7:0] full;
   logic [3:0] didx;

   always_comb begin
      full = {shift_q[6:0], serial_data_pin_in};
      didx = byte_q - SCWR_IDX_DATA0;
      seen_start_d = start_q;
      seen_stop_d = stop_q;
      shift_d = full;
      bit_d = bit_q + 3'h1;
      byte_d = byte_q;
      match_d = match_q;
      tog_d = tog_q;
      stog_d = stog_q;
      out_d = out_q;
      if (start_q != seen_start_q) begin
         // New frame restarts the count at the address byte
         stog_d = ~stog_q;
         bit_d = 3'h1;
         byte_d = 4'h0;
         match_d = 1'b0;
      end else if (stop_q != seen_stop_q) begin
         bit_d = 3'h0;
         byte_d = 4'hf; // Bits after stop are dropped
      end
      if (start_q != seen_start_q) begin
         shift_d = {7'h00, serial_data_pin_in};
      end else if (bit_q == SCWR_BIT_LAST && byte_q != 4'hf) begin
         byte_d = (byte_q == SCWR_IDX_LAST) ? 4'hf : byte_q + 4'h1;
         if (byte_q == 4'h0) begin
            match_d = (full == SCWR_ADDR_BYTE);
         end
         // Command and count bytes only advance the count
         if (byte_q >= SCWR_IDX_DATA0 && match_q) begin
            out_d.index = didx[2:0];
            out_d.value = full;
            tog_d = ~tog_q; // Only completed bytes are sent
         end
      end
   end

   // Serial clock stands still between frames, so reset cannot wait for it
   always_ff @(posedge serial_clock_pin_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         seen_start_q <= 1'b0;
         seen_stop_q <= 1'b0;
         shift_q <= 8'h00;
         bit_q <= 3'h0;
         byte_q <= 4'hf;
         match_q <= 1'b0;
         tog_q <= 1'b0;
         stog_q <= 1'b0;
         out_q <= '0;
      end else begin
         seen_start_q <= seen_start_d;
         seen_stop_q <= seen_stop_d;
         shift_q <= shift_d;
         bit_q <= bit_d;
         byte_q <= byte_d;
         match_q <= match_d;
         tog_q <= tog_d;
         stog_q <= stog_d;
         out_q <= out_d;
      end
   end

   assign start_toggle_out = stog_q;
   assign byte_toggle_out = tog_q;
   assign byte_out = out_q;
endmodule

// File: hw/scwr_pkg.sv
// Constants and carrier types for the serial configuration write receiver.
// Assumes a master that sends one eleven-byte write framed by start/stop.
package scwr_pkg;
   // ==========================================================
   // Framing
   localparam logic [7:0] SCWR_ADDR_BYTE = 8'hd2;
   localparam int SCWR_NUM_DATA = 8;
   localparam logic [3:0] SCWR_IDX_CMD = 4'h1;
   localparam logic [3:0] SCWR_IDX_COUNT = 4'h2;
   localparam logic [3:0] SCWR_IDX_DATA0 = 4'h3;
   localparam logic [3:0] SCWR_IDX_LAST = 4'ha;
   localparam logic [2:0] SCWR_BIT_LAST = 3'h7;
   // ==========================================================
   // Reset values of data bytes 0 to 7
   localparam logic [7:0] SCWR_DEF0 = 8'h04;
   localparam logic [7:0] SCWR_DEF1 = 8'h0f;
   localparam logic [7:0] SCWR_DEF2 = 8'h5f;
   localparam logic [7:0] SCWR_DEF3 = 8'h37;
   localparam logic [7:0] SCWR_DEF4 = 8'h00;
   localparam logic [7:0] SCWR_DEF5 = 8'h13;
   localparam logic [7:0] SCWR_DEF6 = 8'h00;
   localparam logic [7:0] SCWR_DEF7 = 8'h00;

   // Byte handed from the link domain
   typedef struct packed {
      logic [2:0] index;
      logic [7:0] value;
   } scwr_byte_t;

   typedef logic [SCWR_NUM_DATA-1:0][7:0] scwr_cfg_t;
endpackage

// File: hw/scwr_top.sv
// Top of the serial configuration write receiver.
// Assumes clock_in is the system clock; serial pins come from the master.
`timescale 1ns/10ps
module scwr_top
   import scwr_pkg::*;
(
   input wire logic clock_in,
   input wire logic rst_n_in,
   input wire logic serial_clock_pin_in,
   input wire logic serial_data_pin_in,
   output logic serial_data_pin_out,
   output logic serial_data_pin_oe_out,
   output scwr_cfg_t config_out,
   output logic config_update_out
);
   // ==========================================================
   // Link-domain receiver
   logic link_tog;
   logic link_stog;
   scwr_byte_t link_byte;
   scwr_link_rx u_rx (
      .serial_clock_pin_in(serial_clock_pin_in),
      .serial_data_pin_in(serial_data_pin_in),
      .rst_n_in(rst_n_in),
      .start_toggle_out(link_stog),
      .byte_toggle_out(link_tog),
      .byte_out(link_byte)
   );

   // ==========================================================
   // Toggle crossing; the byte word is stable a whole byte time
   logic [2:0] sync_q, sync_d;
   scwr_byte_t hold_q, hold_d;
   logic take;
   always_comb begin
      sync_d = {sync_q[1:0], link_tog};
      take = sync_q[2] != sync_q[1];
      hold_d = take ? link_byte : hold_q;
   end
   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         sync_q <= 3'h0;
         hold_q <= '0;
      end else begin
         sync_q <= sync_d;
         hold_q <= hold_d;
      end
   end

   // ==========================================================
   // Configuration registers with defaults
   scwr_cfg_t cfg_q, cfg_d;
   logic upd_q, upd_d;
   logic take_q, take_d;
   always_comb begin
      take_d = take;
      cfg_d = cfg_q;
      upd_d = 1'b0;
      if (take_q) begin
         cfg_d[hold_q.index] = hold_q.value;
         upd_d = 1'b1;
      end
   end
   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         cfg_q <= {SCWR_DEF7, SCWR_DEF6, SCWR_DEF5, SCWR_DEF4,
                   SCWR_DEF3, SCWR_DEF2, SCWR_DEF1, SCWR_DEF0};
         upd_q <= 1'b0;
         take_q <= 1'b0;
      end else begin
         cfg_q <= cfg_d;
         upd_q <= upd_d;
         take_q <= take_d;
      end
   end

   // Write-only: data pin never driven
   assign serial_data_pin_out = 1'b0;
   assign serial_data_pin_oe_out = 1'b0;
   assign config_out = cfg_q;
   assign config_update_out = upd_q;
   logic unused_stog;
   assign unused_stog = link_stog;
endmodule

// File: verif/scwr_master.sv
// Two-wire master model that writes frames to the receiver.
// Assumes pull-ups: both lines idle high, clock still between frames.
`timescale 1ns/10ps
module scwr_master (
   output logic scl_out,
   output logic sda_out
);
   initial begin
      scl_out = 1'b1;
      sda_out = 1'b1;
   end
   // ========
   // One write: start, n bytes, stop; 48 ns bit period
   task automatic frame(input logic [7:0] b [11], input int n);
      sda_out = 1'b0; // Start while clock high
      #24;
      for (int i = 0; i < n; i++) begin // Byte order
         for (int j = 7; j >= 0; j--) begin // MSB first, no ack slot
            scl_out = 1'b0;
            #12 sda_out = b[i][j]; // Caller sends reserved bits as 0
            #12 scl_out = 1'b1;
            #24;
         end
      end
      scl_out = 1'b0;
      #12 sda_out = 1'b0;
      #12 scl_out = 1'b1;
      #12 sda_out = 1'b1; // Stop
      #24;
   endtask
endmodule

// File: verif/scwr_props.sv
// Checker for the serial configuration write receiver top.
// Assumes it is bound to scwr_top and watches the clock_in domain.
`timescale 1ns/10ps
module scwr_props
   import scwr_pkg::*;
(
   input wire logic clock_in,
   input wire logic rst_n_in,
   input wire logic serial_clock_pin_in,
   input wire logic serial_data_pin_in,
   input wire logic serial_data_pin_out,
   input wire logic serial_data_pin_oe_out,
   input wire scwr_cfg_t config_out,
   input wire logic config_update_out
);
   // ========
   // Output relations
   default clocking @(posedge clock_in); endclocking
   default disable iff (!rst_n_in);
   chk_never_drives: assert property (!serial_data_pin_oe_out)
      else $error("data pin enabled");
   chk_drive_low: assert property (!serial_data_pin_out)
      else $error("data pin output high");
   chk_reset_defaults: assert property (disable iff (1'b0) !rst_n_in |=>
      config_out == {SCWR_DEF7, SCWR_DEF6, SCWR_DEF5, SCWR_DEF4,
      SCWR_DEF3, SCWR_DEF2, SCWR_DEF1, SCWR_DEF0})
      else $error("defaults not loaded");
   chk_reset_quiet: assert property (disable iff (1'b0)
      !rst_n_in |=> !config_update_out) else $error("update in reset");
   chk_change_flag: assert property (!$stable(config_out) |->
      config_update_out || $past(config_update_out))
      else $error("config changed without update");
   chk_pulse_one: assert property (config_update_out |=>
      !config_update_out) else $error("update longer than one cycle");
   chk_data_hold: assert property (config_update_out |=>
      $stable(config_out)[*3]) else $error("config not held");
   chk_idle_quiet: assert property ($stable(serial_clock_pin_in)[*8]
      |=> !config_update_out) else $error("update while link idle");
endmodule
bind scwr_top scwr_props u_props (
   .clock_in(clock_in),
   .rst_n_in(rst_n_in),
   .serial_clock_pin_in(serial_clock_pin_in),
   .serial_data_pin_in(serial_data_pin_in),
   .serial_data_pin_out(serial_data_pin_out),
   .serial_data_pin_oe_out(serial_data_pin_oe_out),
   .config_out(config_out),
   .config_update_out(config_update_out)
);

// File: verif/tb.sv
// Self-checking bench for the serial configuration write receiver.
// Assumes scwr_top, its bound checker and the master model.
`timescale 1ns/10ps
module tb;
   import scwr_pkg::*;
   logic clock_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic scl, sda, sd_out, sd_oe, upd;
   scwr_cfg_t cfg, exp_cfg;
   logic [7:0] f [11];
   int error_cnt = 0;
   int total_checks = 0;
   int upd_cnt = 0;
   int upd_base = 0;
   always #20 clock_in = ~clock_in;
   scwr_master m (.scl_out(scl), .sda_out(sda));
   scwr_top DUT (.clock_in(clock_in), .rst_n_in(rst_n_in),
      .serial_clock_pin_in(scl), .serial_data_pin_in(sda),
      .serial_data_pin_out(sd_out), .serial_data_pin_oe_out(sd_oe),
      .config_out(cfg), .config_update_out(upd));
   // Counts update pulses away from the launching edge
   always @(negedge clock_in) begin
      if (upd === 1'b1) begin
         upd_cnt <= upd_cnt + 1;
      end
   end
   // ========
   // Shared tasks
   task automatic chk_cfg();
      @(negedge clock_in);
      total_checks++;
      if (cfg !== exp_cfg || sd_oe !== 1'b0 || sd_out !== 1'b0) begin
         error_cnt++;
         $display("BAD %0t config %h", $time, cfg);
      end
   endtask
   // Update pulses seen since the last frame began
   task automatic chk_upd(input int n);
      total_checks++;
      if (upd_cnt - upd_base != n) begin
         error_cnt++;
         $display("BAD %0t updates %0d", $time, upd_cnt - upd_base);
      end
   endtask
   task automatic send(input logic [7:0] a, input int n);
      f[0] = a;
      upd_base = upd_cnt;
      m.frame(f, n);
      repeat (10) @(posedge clock_in);
   endtask
   task automatic finish_test();
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // ========
   // Scenarios
   task automatic t_full();
      f[1] = 8'hff;
      f[2] = 8'h01; // Count of one must not cut the write short
      for (int k = 0; k < 8; k++) begin
         f[k + 3] = 8'h31 + 8'h08 * k[7:0];
         exp_cfg[k] = f[k + 3];
      end
      send(SCWR_ADDR_BYTE, 11);
      chk_cfg();
      chk_upd(8);
   endtask
   task automatic t_wrong_addr();
      logic [7:0] bad [3] = '{8'hd3, 8'h52, 8'hd0};
      for (int k = 3; k < 11; k++) f[k] = 8'h0a;
      for (int i = 0; i < 3; i++) begin
         send(bad[i], 11);
         chk_cfg();
         chk_upd(0);
      end
   endtask
   task automatic t_short();
      f[3] = 8'h5a;
      f[4] = 8'h3c;
      exp_cfg[0] = 8'h5a;
      exp_cfg[1] = 8'h3c;
      send(SCWR_ADDR_BYTE, 5);
      chk_cfg();
      chk_upd(2);
   endtask
   initial begin
      exp_cfg = {SCWR_DEF7, SCWR_DEF6, SCWR_DEF5, SCWR_DEF4,
         SCWR_DEF3, SCWR_DEF2, SCWR_DEF1, SCWR_DEF0};
      repeat (6) @(posedge clock_in);
      rst_n_in <= 1'b1;
      repeat (2) @(posedge clock_in);
      chk_cfg();
      t_full();
      t_wrong_addr();
      t_short();
      finish_test();
   end
   // Watchdog against a hung run
   initial begin
      #200000;
      error_cnt++;
      finish_test();
   end
endmodule
